//--- bench/lsb_lin_master.sv
/*
 lsb_lin_master: lin master model, hands whole frames to the decoder.
 assumes the bench clock and a link layer that checked the checksum.
*/
`timescale 1ns/1ps
`default_nettype none
module lsb_lin_master (
    input wire logic pclk,
    output logic frame_valid,
    output logic [7:0] id,
    output logic [7:0] d1,
    output logic [7:0] d2
);
    initial
    begin
        frame_valid = 1'b0;
        id = 8'h00;
        d1 = 8'h00;
        d2 = 8'h00;
    end
    // bad flips parity bit 6 on purpose
    task automatic send(input logic [5:0] dyn, input logic [7:0] b1, input logic [7:0] b2, input logic bad);
        logic [7:0] p;
        p = {2'b00, dyn};
        p[6] = p[0] ^ p[1] ^ p[2] ^ p[4] ^ bad;
        p[7] = ~(p[1] ^ p[3] ^ p[4] ^ p[5]);
        @(posedge pclk);
        frame_valid <= 1'b1;
        id <= p;
        d1 <= b1;
        d2 <= b2;
        @(posedge pclk);
        frame_valid <= 1'b0;
        id <= ~p;
        d1 <= ~b1;
        d2 <= ~b2;
    endtask : send
endmodule : lsb_lin_master
`default_nettype wire

//--- bench/tb.sv
/*
 tb: apb and frame tests of lsb_top.
 assumes lsb_lin_master as the frame source.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    import lsb_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, frame_valid, pin_out, oe_n, sw_state, decel, load_tp, probe;
    logic [7:0] fid, fd1, fd2;
    logic motion = 1'b0, stopped = 1'b0, ref_run = 1'b0, hot = 1'b0, integ = 1'b0, pin_in = 1'b1;
    int fail_count = 0, cmp_count = 0;
    always #4 pclk = ~pclk;
    lsb_lin_master lsb_lin_master_i (.pclk(pclk), .frame_valid(frame_valid), .id(fid), .d1(fd1), .d2(fd2));
    lsb_top lsb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_valid(frame_valid), .dynamic_frame_identifier(fid), .frame_data1(fd1), .frame_data2(fd2),
        .motion_active(motion), .motor_stopped(stopped), .two_point_reference_run(ref_run),
        .over_temperature(hot), .backemf_integrator_out(integ), .switch_input_pin_in(pin_in),
        .switch_input_pin_out(pin_out), .switch_input_pin_oe_n(oe_n), .switch_state(sw_state),
        .decelerate_halt_cmd(decel), .load_target_position(load_tp), .backemf_probe_active(probe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // pready read as sampled at each rising edge; watchdog ends a hang
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic frame(input logic [7:0] b1, input logic [7:0] b2, input logic bad);
        lsb_lin_master_i.send(6'h0a, b1, b2, bad);
        repeat (3) @(negedge pclk);
    endtask : frame
    task automatic halt_done();
        @(posedge pclk);
        stopped <= 1'b1;
        repeat (2) @(negedge pclk);
        check({decel, load_tp}, 2'b01, "halt load");
        @(posedge pclk);
        stopped <= 1'b0;
        repeat (2) @(negedge pclk);
    endtask : halt_done
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (5000) @(posedge pclk);
        fail_count++;
        tally_and_finish();
    end
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        check({oe_n, probe, decel}, 3'b100, "reset pins");
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h0, "ctrl reset");
        @(negedge pclk);
        check(pready, 1'b0, "pready one cycle");
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd, 32'h0, "status reset");
        apb(1'b0, 8'h08, 32'h0);
        check(err, 1'b1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        apb(1'b1, ADDR_CTRL, 32'h15);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check(rd, 32'h15, "ctrl rw");
        $display("test registers done");
        motion <= 1'b1;
        frame(8'h8f, 8'h03, 1'b0);
        check(decel, 1'b1, "broadcast stop");
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd[2:1], 2'd1, "halt state");
        halt_done();
        @(posedge pclk);
        ref_run <= 1'b1;
        frame(8'h8f, 8'h00, 1'b0);
        check(decel, 1'b0, "stop in ref run");
        @(posedge pclk);
        ref_run <= 1'b0;
        frame(8'h8f, 8'h96, 1'b0);
        check(decel, 1'b0, "address miss");
        frame(8'haf, 8'h00, 1'b0);
        check(decel, 1'b0, "other code");
        frame(8'h0f, 8'h00, 1'b0);
        check(decel, 1'b0, "flag bit clear");
        frame(8'h8f, 8'h95, 1'b0);
        check(decel, 1'b1, "address hit");
        halt_done();
        @(posedge pclk);
        hot <= 1'b1;
        @(posedge pclk);
        hot <= 1'b0;
        repeat (2) @(negedge pclk);
        check(decel, 1'b1, "thermal stop");
        halt_done();
        $display("test stop done");
        frame(8'h8f, 8'h00, 1'b1);
        check(decel, 1'b0, "bad parity");
        lsb_lin_master_i.send(6'h2a, 8'h8f, 8'h00, 1'b0);
        repeat (3) @(negedge pclk);
        check(decel, 1'b0, "id bit 5 set");
        apb(1'b0, ADDR_STATUS, 32'h0);
        check(rd[15:8], 8'h02, "reject count");
        check(sw_state, 1'b1, "pin sampled");
        integ <= 1'b1;
        frame(8'h9f, 8'h40, 1'b0);
        check({probe, oe_n, pin_out}, 3'b101, "probe on");
        @(posedge pclk);
        pin_in <= 1'b0;
        integ <= 1'b0;
        repeat (3) @(negedge pclk);
        check({sw_state, pin_out}, 2'b10, "pin frozen");
        frame(8'h8f, 8'h00, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0);
        check({rd[0], probe, oe_n}, 3'b110, "probe sticky");
        $display("test probe done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(negedge pclk);
        check({probe, oe_n, decel}, 3'b010, "reset clears probe");
        $display("test reset done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire

//--- core/lsb_cmd_decode.sv
/*
 lsb_cmd_decode: combinational decode of the two data bytes of a
 general-purpose frame into stop and probe hits for this node.
 assumes the frame identifier was already checked by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module lsb_cmd_decode
    import lsb_pkg::*;
(
    input wire logic [7:0] data1,
    input wire logic [7:0] data2,
    input wire logic [lsb_pkg::NODE_W-1:0] node_addr,
    output logic stop_hit,
    output logic probe_hit
);
    logic for_us;
    logic is_cmd;

    always_comb
    begin
        // broadcast flag zero means all nodes; one means address match
        for_us = !data2[BROAD_BIT] || (data2[NODE_W-1:0] == node_addr);
        is_cmd = data1[CMD_FLAG_BIT] && for_us;
        // only the data bytes select the command
        stop_hit = is_cmd && (data1[6:0] == CMD_STOP);
        probe_hit = is_cmd && (data1[6:0] == CMD_PROBE);
    end
endmodule : lsb_cmd_decode
`default_nettype wire

//--- core/lsb_pkg.sv
/*
 lsb_pkg: constants, types and helpers for the stop and back-emf probe decoder.
 assumes a lin data-link layer that hands over whole, checksum-verified frames.
 // Contract
 // - identifier bit 5 zero, parity bits checked
 // - stop: data1 bit7 set, code 0x0f
 // - broadcast flag zero: every node stops
 // - probe: same layout, code 0x1f
 // - broadcast flag zero: every node probes
 // - probe drives integrator onto switch pin
 // - probe stays active until power-on reset
 // - probe blocks switch pin sampling
 // - command taken from data, not identifier
 // - stop decelerates, halts, loads target position
 // - stop ignored during two-point reference run
 // - over-temperature also raises the stop
*/
package lsb_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NODE_W = 7;
    localparam int CNT_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
    localparam logic [NODE_W-1:0] NODE_ADDR_RESET = 7'h00;
    localparam logic [6:0] CMD_STOP = 7'h0f;
    localparam logic [6:0] CMD_PROBE = 7'h1f;
    localparam int ID_ZERO_BIT = 5;
    localparam int CMD_FLAG_BIT = 7;
    localparam int BROAD_BIT = 7;
    localparam int ST_PROBE_BIT = 0;
    localparam int ST_HALT_LO = 1;
    localparam int ST_CNT_LO = 8;

    typedef enum logic [1:0] {HALT_IDLE, HALT_DECEL, HALT_LOAD} lsb_halt_t;

    // lin identifier parity: p0 = i0^i1^i2^i4, p1 = ~(i1^i3^i4^i5)
    function automatic logic lsb_parity_ok(input logic [7:0] id);
        logic p0;
        logic p1;
        p0 = id[0] ^ id[1] ^ id[2] ^ id[4];
        p1 = ~(id[1] ^ id[3] ^ id[4] ^ id[5]);
        return (id[6] == p0) && (id[7] == p1);
    endfunction : lsb_parity_ok
endpackage : lsb_pkg

//--- core/lsb_top.sv
/*
 lsb_top: stop and back-emf probe command decoder with apb registers.
 assumes frame_valid is a one-cycle pulse with id and data bytes stable,
 and the positioner reports motion, motor_stopped and takes decel_halt_cmd.
*/
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lsb_top
    import lsb_pkg::*;
#(
    parameter int NODE_BITS = lsb_pkg::NODE_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lsb_pkg::ADDR_W-1:0] paddr,
    input wire logic [lsb_pkg::DATA_W-1:0] pwdata,
    output logic [lsb_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_valid,
    input wire logic [7:0] dynamic_frame_identifier,
    input wire logic [7:0] frame_data1,
    input wire logic [7:0] frame_data2,
    input wire logic motion_active,
    input wire logic motor_stopped,
    input wire logic two_point_reference_run,
    input wire logic over_temperature,
    input wire logic backemf_integrator_out,
    input wire logic switch_input_pin_in,
    output logic switch_input_pin_out,
    output logic switch_input_pin_oe_n,
    output logic switch_state,
    output logic decelerate_halt_cmd,
    output logic load_target_position,
    output logic backemf_probe_active
);
    import lsb_pkg::*;

    if (NODE_BITS != NODE_W)
    begin : g_check
        $error("lsb_top: node address must be seven bits");
    end

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
        logic [NODE_W-1:0] node_addr;
        logic [CNT_W-1:0] reject_count;
        lsb_halt_t halt;
        logic decel;
        logic load_target;
        logic probe;
        logic sw_out;
        logic sw_oe_n;
        logic sw_state;
    } lsb_state_t;

    lsb_state_t st;
    lsb_state_t next_st;
    logic stop_hit;
    logic probe_hit;
    logic id_ok;
    logic stop_trig;

    lsb_cmd_decode u_decode (
        .data1(frame_data1),
        .data2(frame_data2),
        .node_addr(st.node_addr),
        .stop_hit(stop_hit),
        .probe_hit(probe_hit)
    );

    always_comb
    begin
        next_st = st;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        next_st.load_target = 1'b0;
        // identifier: parity and bit 5 only, its value is not decoded
        id_ok = lsb_parity_ok(dynamic_frame_identifier)
            && !dynamic_frame_identifier[ID_ZERO_BIT];
        stop_trig = (frame_valid && id_ok && stop_hit && !two_point_reference_run)
            || over_temperature;

        // apb: one wait state, write commits at the pready edge
        if (psel && penable && !st.pready)
        begin
            next_st.pready = 1'b1;
            next_st.prdata = '0;
            case (paddr)
                ADDR_CTRL:
                begin
                    next_st.prdata = DATA_W'(st.node_addr);
                end
                ADDR_STATUS:
                begin
                    next_st.prdata[ST_PROBE_BIT] = st.probe;
                    next_st.prdata[ST_HALT_LO +: 2] = st.halt;
                    next_st.prdata[ST_CNT_LO +: CNT_W] = st.reject_count;
                end
                default:
                begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
        else if (psel && penable && st.pready && pwrite && (paddr == ADDR_CTRL))
        begin
            next_st.node_addr = pwdata[NODE_W-1:0];
        end

        // identifier check failures are counted
        if (frame_valid && !id_ok)
        begin
            next_st.reject_count = CNT_W'(st.reject_count + 1'b1);
        end

        // decelerating stop sequence
        case (st.halt)
            HALT_IDLE:
            begin
                if (stop_trig && motion_active)
                begin
                    next_st.halt = HALT_DECEL;
                    next_st.decel = 1'b1;
                end
            end
            HALT_DECEL:
            begin
                if (motor_stopped)
                begin
                    next_st.halt = HALT_LOAD;
                    next_st.decel = 1'b0;
                    next_st.load_target = 1'b1;
                end
            end
            HALT_LOAD:
            begin
                next_st.halt = HALT_IDLE;
            end
            default:
            begin
                next_st.halt = HALT_IDLE;
                next_st.decel = 1'b0;
            end
        endcase

        // probe is sticky, only reset clears it
        if (frame_valid && id_ok && probe_hit)
        begin
            next_st.probe = 1'b1;
        end

        if (st.probe)
        begin
            next_st.sw_out = backemf_integrator_out;
            next_st.sw_oe_n = 1'b0;
        end
        else
        begin
            next_st.sw_out = 1'b0;
            next_st.sw_oe_n = 1'b1;
            next_st.sw_state = switch_input_pin_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st.prdata <= '0;
            st.pready <= 1'b0;
            st.pslverr <= 1'b0;
            st.node_addr <= NODE_ADDR_RESET;
            st.reject_count <= '0;
            st.halt <= HALT_IDLE;
            st.decel <= 1'b0;
            st.load_target <= 1'b0;
            st.probe <= 1'b0;
            st.sw_out <= 1'b0;
            st.sw_oe_n <= 1'b1;
            st.sw_state <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign switch_input_pin_out = st.sw_out;
    assign switch_input_pin_oe_n = st.sw_oe_n;
    assign switch_state = st.sw_state;
    assign decelerate_halt_cmd = st.decel;
    assign load_target_position = st.load_target;
    assign backemf_probe_active = st.probe;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_decel_wait;
        decelerate_halt_cmd && motor_stopped;
    endsequence

    sequence s_halt_finish;
        load_target_position && !decelerate_halt_cmd ##1 !load_target_position && st.halt == HALT_IDLE;
    endsequence

    logic reject_count_moved;
    logic [CNT_W-1:0] last_count;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_count <= '0;
        end
        else
        begin
            last_count <= st.reject_count;
        end
    end
    assign reject_count_moved = st.reject_count == CNT_W'(last_count + 1'b1);

    id_reject_a: assert property (
        frame_valid && dynamic_frame_identifier[ID_ZERO_BIT]
        |=> reject_count_moved)
        else $error("identifier with bit 5 set was not rejected");

    stop_start_a: assert property (
        frame_valid && id_ok && stop_hit && !two_point_reference_run && motion_active
        && st.halt == HALT_IDLE |=> decelerate_halt_cmd)
        else $error("accepted stop did not start deceleration");

    halt_load_a: assert property (
        s_decel_wait |=> s_halt_finish)
        else $error("halt did not load target position once");

    ref_ignore_a: assert property (
        st.halt == HALT_IDLE && two_point_reference_run && !over_temperature
        |=> !decelerate_halt_cmd)
        else $error("stop acted on during reference run");

    thermal_stop_a: assert property (
        over_temperature && motion_active && st.halt == HALT_IDLE |=> decelerate_halt_cmd)
        else $error("over-temperature did not raise the stop");

    probe_set_a: assert property (
        frame_valid && id_ok && frame_data1 == {1'b1, CMD_PROBE} && !frame_data2[BROAD_BIT]
        |=> backemf_probe_active ##1 !switch_input_pin_oe_n)
        else $error("broadcast probe not taken");

    probe_hold_a: assert property (
        backemf_probe_active |=> backemf_probe_active)
        else $error("probe dropped before reset");

    pin_route_a: assert property (
        backemf_probe_active |=> switch_input_pin_out == $past(backemf_integrator_out)
        && !switch_input_pin_oe_n)
        else $error("integrator not routed to switch pin");

    sample_block_a: assert property (
        backemf_probe_active |=> $stable(switch_state))
        else $error("switch pin sampled during probe");

    addr_filter_a: assert property (
        frame_valid && !backemf_probe_active && frame_data2[BROAD_BIT]
        && frame_data2[NODE_W-1:0] != st.node_addr |=> !backemf_probe_active)
        else $error("probe taken for another node");
endmodule : lsb_top
`default_nettype wire
